// ---- periph_window_pkg.sv ----
package periph_window_pkg;
    localparam logic [7:0] OFS_RELOC = 8'hFE;
    localparam logic [7:0] OFS_CLKDIS = 8'hFA;
    localparam logic [7:0] OFS_RELEASE = 8'hF4;
    localparam logic [7:0] OFS_SYSCFG = 8'hF0;
    localparam logic [7:0] OFS_PWRDN = 8'h46;
    localparam logic [15:0] RELOC_RESET = 16'h00FF;
    localparam logic [15:0] RELOC_WMASK = 16'h5FFF;
    localparam int RELOC_SLAVE_BIT = 14;
    localparam int RELOC_MEM_BIT = 12;
    localparam int RELOC_BASE_MSB = 11;
    localparam int SYSCFG_PSEN_BIT = 15;
    localparam int SYSCFG_DIV_MSB = 2;
    localparam int CLKDIS_LSB = 11;
    localparam int CLKDIS_MSB = 15;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [4:0] CLKSTOP_RESET = 5'h00;
    localparam logic [6:0] DIVCNT_RESET = 7'h00;
    localparam logic [7:0] ONE_8 = 8'h01;
    localparam logic [15:0] DATA_ZERO = 16'h0000;
    typedef struct packed {
        logic [19:0] addr;
        logic isMem;
        logic rd;
        logic wr;
        logic [15:0] wrData;
    } cpu_access_type;
    typedef struct packed {
        logic psEnable;
        logic [2:0] divSel;
        logic [4:0] clkStop;
    } power_ctrl_type;
endpackage

// ---- peripheral_block_relocation.sv ----
`timescale 1ns/10ps
module peripheral_block_relocation #(
    parameter logic [15:0] RELEASE_ID = 16'h1234 // arbitrary value
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire periph_window_pkg::cpu_access_type cpuAccess,
    input wire logic extIrq,
    output logic claim,
    output logic rdValid,
    output logic [15:0] rdData,
    output logic periphSel,
    output logic periphWr,
    output logic [7:0] periphOfs,
    output logic slaveMode,
    output logic windowIsMem,
    output logic [11:0] windowBaseBits,
    output periph_window_pkg::power_ctrl_type pwrCtrl,
    output logic opTick
);
    logic [15:0] relocWin_ff;
    logic psEn_ff;
    logic [2:0] divSel_ff;
    logic [4:0] clkStop_ff;
    logic [6:0] divCnt_ff;
    logic opTick_ff;
    logic claim_ff;
    logic rdValid_ff;
    logic [15:0] rdData_ff;
    logic periphSel_ff;
    logic periphWr_ff;
    logic [7:0] periphOfs_ff;

    // decode
    wire access = cpuAccess.rd | cpuAccess.wr;
    wire spaceMatch = cpuAccess.isMem == relocWin_ff[periph_window_pkg::RELOC_MEM_BIT];
    wire baseMatch = cpuAccess.addr[19:8]
        == relocWin_ff[periph_window_pkg::RELOC_BASE_MSB:0];
    wire hit = access & spaceMatch & baseMatch;
    // word registers: byte lane bit ignored
    wire [7:0] ofs = {cpuAccess.addr[7:1], 1'b0};
    wire selReloc = hit && ofs == periph_window_pkg::OFS_RELOC;
    wire selRelease = hit && ofs == periph_window_pkg::OFS_RELEASE;
    wire selSysCfg = hit && ofs == periph_window_pkg::OFS_SYSCFG;
    wire selClkDis = hit && ofs == periph_window_pkg::OFS_CLKDIS;
    wire ownReg = selReloc | selRelease | selSysCfg | selClkDis;
    wire wrReloc = selReloc & cpuAccess.wr;
    wire wrSysCfg = selSysCfg & cpuAccess.wr;
    wire wrClkDis = selClkDis & cpuAccess.wr;

    wire [15:0] sysCfgView = {psEn_ff, 12'h000, divSel_ff};
    wire [15:0] clkDisView = {clkStop_ff, 11'h000};
    wire [15:0] rdMux =
        selReloc ? relocWin_ff :
        selRelease ? RELEASE_ID :
        selSysCfg ? sysCfgView :
        selClkDis ? clkDisView :
        periph_window_pkg::DATA_ZERO;

    // power-save divider: 2^divSel cycles per tick
    wire [6:0] divLimit = psEn_ff ? 7'((periph_window_pkg::ONE_8 << divSel_ff)
        - periph_window_pkg::ONE_8) : periph_window_pkg::DIVCNT_RESET;
    wire divWrap = divCnt_ff >= divLimit;
    wire [6:0] nxt_divCnt = divWrap ? periph_window_pkg::DIVCNT_RESET : 7'(divCnt_ff + 7'h01);
    // software write wins over the interrupt clear: the newest program stands
    wire nxt_psEn = wrSysCfg ? cpuAccess.wrData[periph_window_pkg::SYSCFG_PSEN_BIT] :
        (extIrq ? 1'b0 : psEn_ff);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            relocWin_ff <= periph_window_pkg::RELOC_RESET;
        end else if (clkEn && wrReloc) begin
            // base bits 19-16 kept as written; software keeps them zero for I/O
            relocWin_ff <= cpuAccess.wrData & periph_window_pkg::RELOC_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            psEn_ff <= 1'b0;
            divSel_ff <= periph_window_pkg::DIV_RESET;
            clkStop_ff <= periph_window_pkg::CLKSTOP_RESET;
        end else if (clkEn) begin
            psEn_ff <= nxt_psEn;
            if (wrSysCfg) begin
                divSel_ff <= cpuAccess.wrData[periph_window_pkg::SYSCFG_DIV_MSB:0];
            end
            if (wrClkDis) begin
                clkStop_ff <= cpuAccess.wrData[periph_window_pkg::CLKDIS_MSB:
                    periph_window_pkg::CLKDIS_LSB];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            divCnt_ff <= periph_window_pkg::DIVCNT_RESET;
            opTick_ff <= 1'b0;
        end else if (clkEn) begin
            divCnt_ff <= nxt_divCnt;
            opTick_ff <= divWrap;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            claim_ff <= 1'b0;
            rdValid_ff <= 1'b0;
            rdData_ff <= periph_window_pkg::DATA_ZERO;
            periphSel_ff <= 1'b0;
            periphWr_ff <= 1'b0;
            periphOfs_ff <= 8'h00;
        end else if (clkEn) begin
            claim_ff <= hit;
            rdValid_ff <= hit & cpuAccess.rd;
            rdData_ff <= rdMux;
            // other window offsets are handed to their owning units
            periphSel_ff <= hit & ~ownReg;
            periphWr_ff <= hit & ~ownReg & cpuAccess.wr;
            periphOfs_ff <= ofs;
        end
    end

    assign claim = claim_ff;
    assign rdValid = rdValid_ff;
    assign rdData = rdData_ff;
    assign periphSel = periphSel_ff;
    assign periphWr = periphWr_ff;
    assign periphOfs = periphOfs_ff;
    assign slaveMode = relocWin_ff[periph_window_pkg::RELOC_SLAVE_BIT];
    assign windowIsMem = relocWin_ff[periph_window_pkg::RELOC_MEM_BIT];
    assign windowBaseBits = relocWin_ff[periph_window_pkg::RELOC_BASE_MSB:0];
    assign pwrCtrl = {psEn_ff, divSel_ff, clkStop_ff};
    assign opTick = opTick_ff;

    // checks
    sequence s_relocWrite;
        clkEn && wrReloc;
    endsequence
    sequence s_fullSpeed;
        (clkEn && !psEn_ff)[*2];
    endsequence

    property p_resetBase;
        @(posedge clk) sys_rst |=> relocWin_ff == periph_window_pkg::RELOC_RESET;
    endproperty
    a_resetBase: assert property (p_resetBase) else $error("window not at reset base");

    property p_relocWrite;
        @(posedge clk) disable iff (sys_rst)
        s_relocWrite |=> relocWin_ff == ($past(cpuAccess.wrData)
            & periph_window_pkg::RELOC_WMASK);
    endproperty
    a_relocWrite: assert property (p_relocWrite) else $error("relocation write lost");

    property p_wrongSpace;
        @(posedge clk) disable iff (sys_rst)
        clkEn && access && !spaceMatch |=> !claim_ff;
    endproperty
    a_wrongSpace: assert property (p_wrongSpace) else $error("claimed other space");

    property p_claim;
        @(posedge clk) disable iff (sys_rst)
        clkEn && hit |=> claim_ff;
    endproperty
    a_claim: assert property (p_claim) else $error("matching access not claimed");

    // frozen edges hold the claim, so only enabled edges are compared
    property p_claimFollow;
        @(posedge clk) disable iff (sys_rst)
        clkEn && !sys_rst |=> claim_ff == $past(hit);
    endproperty
    a_claimFollow: assert property (p_claimFollow) else $error("claim not from last access");

    property p_slave;
        @(posedge clk) disable iff (sys_rst)
        s_relocWrite |=> slaveMode == $past(cpuAccess.wrData[periph_window_pkg::RELOC_SLAVE_BIT]);
    endproperty
    a_slave: assert property (p_slave) else $error("slave select wrong");

    property p_release;
        @(posedge clk) disable iff (sys_rst)
        clkEn && selRelease |=> rdData_ff == RELEASE_ID && $stable(relocWin_ff);
    endproperty
    a_release: assert property (p_release) else $error("release code wrong");

    property p_periphSel;
        @(posedge clk) disable iff (sys_rst)
        clkEn && hit && ofs == periph_window_pkg::OFS_PWRDN
        |=> periphSel_ff && periphOfs_ff == periph_window_pkg::OFS_PWRDN;
    endproperty
    a_periphSel: assert property (p_periphSel) else $error("offset not selected");

    property p_fullSpeed;
        @(posedge clk) disable iff (sys_rst)
        s_fullSpeed |=> opTick_ff;
    endproperty
    a_fullSpeed: assert property (p_fullSpeed) else $error("full speed tick missing");

    property p_irqWake;
        @(posedge clk) disable iff (sys_rst)
        clkEn && extIrq && !wrSysCfg |=> !psEn_ff;
    endproperty
    a_irqWake: assert property (p_irqWake) else $error("power-save not left");

    property p_clkStop;
        @(posedge clk) disable iff (sys_rst)
        clkEn && wrClkDis |=> clkStop_ff
            == $past(cpuAccess.wrData[periph_window_pkg::CLKDIS_MSB:periph_window_pkg::CLKDIS_LSB]);
    endproperty
    a_clkStop: assert property (p_clkStop) else $error("clock gate write lost");

    // enable low freezes the window position and the power state
    property p_freeze;
        @(posedge clk) disable iff (sys_rst)
        !clkEn && !sys_rst |=> $stable(relocWin_ff) && $stable(claim_ff) && $stable(psEn_ff);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with enable low");
endmodule

// ---- tb_peripheral_block_relocation.sv ----
`timescale 1ns/10ps
module tb_peripheral_block_relocation;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    logic extIrq = 1'b0;
    periph_window_pkg::cpu_access_type cpuAccess = '0;
    logic claim, rdValid, periphSel, periphWr, slaveMode, windowIsMem, opTick;
    logic [15:0] rdData;
    logic [7:0] periphOfs;
    logic [11:0] windowBaseBits;
    periph_window_pkg::power_ctrl_type pwrCtrl;
    logic taken = 1'b0;
    logic [18:0] note;
    logic [18:0] expQ[$];
    logic [11:0] base;
    logic slv;
    int ticks;
    int mismatches = 0;
    int num_checks = 0;
    always #2 clk = ~clk;
    peripheral_block_relocation uut (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .cpuAccess(cpuAccess),
        .extIrq(extIrq),
        .claim(claim),
        .rdValid(rdValid),
        .rdData(rdData),
        .periphSel(periphSel),
        .periphWr(periphWr),
        .periphOfs(periphOfs),
        .slaveMode(slaveMode),
        .windowIsMem(windowIsMem),
        .windowBaseBits(windowBaseBits),
        .pwrCtrl(pwrCtrl),
        .opTick(opTick)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // note layout: claim, rdValid, periphSel, read data
    task automatic acc(input logic [19:0] a, input logic m, input logic w,
                       input logic [15:0] d, input logic [18:0] e);
        @(posedge clk);
        cpuAccess <= '{addr: a, isMem: m, rd: ~w, wr: w, wrData: d};
        expQ.push_back(e);
        @(posedge clk);
        cpuAccess.rd <= 1'b0;
        cpuAccess.wr <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // answer lands on the same edge that takes the access
    always @(posedge clk) taken <= cpuAccess.rd | cpuAccess.wr;
    always @(negedge clk) begin
        if (taken && expQ.size() > 0) begin
            note = expQ.pop_front();
            chk({claim, rdValid, periphSel}, note[18:16]);
            // rdData only meaningful with rdValid
            if (note[17]) chk(rdData, note[15:0]);
        end
    end
    initial begin
        #(4 * 1000);
        mismatches++;
        report_and_stop();
    end
    initial begin
        void'($urandom(99));
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        acc(20'h0FFFE, 1'b0, 1'b0, 16'h0000, 19'h600FF);
        acc(20'h0FFFE, 1'b1, 1'b0, 16'h0000, 19'h00000);
        acc(20'h0FFF4, 1'b0, 1'b0, 16'h0000, 19'h61234);
        acc(20'h0FFF4, 1'b0, 1'b1, 16'hFFFF, 19'h40000);
        acc(20'h0FFF4, 1'b0, 1'b0, 16'h0000, 19'h61234);
        acc(20'h0FF46, 1'b0, 1'b0, 16'h0000, 19'h70000);
        acc(20'h0FFFA, 1'b0, 1'b1, 16'hA800, 19'h40000);
        @(negedge clk);
        chk(pwrCtrl.clkStop, 5'h15);
        $display("test reset map done");
        acc(20'h0FFF0, 1'b0, 1'b1, 16'h8002, 19'h40000);
        ticks = 0;
        repeat (8) @(posedge clk);
        // whole number of divide-by-4 periods, so phase does not matter
        repeat (64) begin
            @(posedge clk);
            #1;
            if (opTick === 1'b1) ticks++;
        end
        chk(ticks, 16);
        @(posedge clk);
        extIrq <= 1'b1;
        @(posedge clk);
        extIrq <= 1'b0;
        @(negedge clk);
        chk(pwrCtrl.psEnable, 1'b0);
        $display("test power save done");
        base = 12'($urandom);
        slv = 1'($urandom);
        acc(20'h0FFFE, 1'b0, 1'b1, {1'b1, slv, 1'b1, 1'b1, base}, 19'h40000);
        @(negedge clk);
        chk({windowIsMem, slaveMode, windowBaseBits}, {1'b1, slv, base});
        acc(20'h0FFFE, 1'b0, 1'b0, 16'h0000, 19'h00000);
        acc({base, 8'hFE}, 1'b1, 1'b0, 16'h0000, {3'b110, 1'b0, slv, 2'b01, base});
        acc({base, 8'hF4}, 1'b0, 1'b0, 16'h0000, 19'h00000);
        acc({base ^ 12'h001, 8'hFE}, 1'b1, 1'b0, 16'h0000, 19'h00000);
        repeat (2) @(negedge clk);
        $display("test relocation done");
        // mid-run reset puts the window back at FF00h in I/O space
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        acc(20'h0FFFE, 1'b0, 1'b0, 16'h0000, 19'h600FF);
        // I/O window: software keeps base bits 19-16 zero; no chip select overlaps it
        base = {4'h0, 8'($urandom)};
        acc(20'h0FFFE, 1'b0, 1'b1, {4'h0, base}, 19'h40000);
        acc({base, 8'hFA}, 1'b0, 1'b0, 16'h0000, 19'h60000);
        // enable low: a write at the live window must neither land nor be claimed
        @(posedge clk);
        clkEn <= 1'b0;
        acc({base, 8'hFE}, 1'b0, 1'b1, 16'h1ABC, 19'h00000);
        @(negedge clk);
        chk({windowIsMem, windowBaseBits}, {1'b0, base});
        @(posedge clk);
        clkEn <= 1'b1;
        $display("test reset and freeze done");
        report_and_stop();
    end
endmodule
